/* File: psfs_sequencer.sv */
// control state machine of a high-side protection switch
`timescale 1ns/100ps
`include "psfs_map.svh"
module psfs_sequencer #(
    parameter int CNT_W = `PSFS_CNT_W,
    parameter logic [CNT_W-1:0] OVP_DEB_CYC = CNT_W'(`PSFS_OVP_DEB_CYC),
    parameter logic [CNT_W-1:0] TON_DELAY_CYC = CNT_W'(`PSFS_TON_DELAY_CYC),
    parameter logic [CNT_W-1:0] SCP_CYC = CNT_W'(`PSFS_SCP_CYC),
    parameter logic [CNT_W-1:0] AR_RETRY_CYC = CNT_W'(`PSFS_AR_RETRY_CYC),
    parameter logic [CNT_W-1:0] LO_RETRY_CYC = CNT_W'(`PSFS_LO_RETRY_CYC),
    parameter int RETRY_W = `PSFS_RETRY_W,
    parameter logic [RETRY_W-1:0] LO_RETRY_COUNT = RETRY_W'(`PSFS_LO_RETRY_COUNT)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host control
    input wire logic enable_i,
    input wire logic overvolt_level_select_i,
    // static variant: 0 auto-restart, 1 latch-off
    input wire logic variant_latchoff_i,
    // analog comparators
    input wire logic undervoltage_lockout_i,
    input wire logic overvolt_trip_high_i,
    input wire logic overvolt_trip_low_i,
    input wire logic reverse_flow_block_i,
    input wire logic thermal_shutdown_i,
    input wire logic thermal_cool_i,
    input wire logic current_limit_active_i,
    input wire logic softstart_done_i,
    // switch control
    output logic switch_on_o,
    output logic softstart_run_o,
    output logic current_limit_en_o,
    // open-drain fault flag
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_o,
    // status
    output logic overvolt_level_low_o,
    output logic latched_off_o,
    output logic [3:0] state_o
);
    psfs_pkg::psfs_state_e state_reg;
    psfs_pkg::psfs_state_e state_next;
    logic enabled_prev_reg;
    logic enabled_prev_next;
    logic ov_sel_reg;
    logic ov_sel_next;
    logic tsd_hold_reg;
    logic tsd_hold_next;
    logic [RETRY_W-1:0] retry_reg;
    logic [RETRY_W-1:0] retry_next;
    logic switch_reg;
    logic switch_next;
    logic ss_reg;
    logic ss_next;
    logic ilim_reg;
    logic ilim_next;
    logic fault_reg;
    logic fault_next;
    logic latched_reg;
    logic latched_next;

    logic enabled;
    logic enable_rise;
    logic ov_trip;
    logic any_fault;
    logic latch_var;

    psfs_tmr_if #(.CNT_W(CNT_W)) ovp_t ();
    psfs_tmr_if #(.CNT_W(CNT_W)) seq_t ();
    psfs_tmr_if #(.CNT_W(CNT_W)) scp_t ();

    psfs_timer #(.CNT_W(CNT_W)) u_ovp_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(ovp_t.tmr)
    );

    psfs_timer #(.CNT_W(CNT_W)) u_seq_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(seq_t.tmr)
    );

    psfs_timer #(.CNT_W(CNT_W)) u_scp_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(scp_t.tmr)
    );

    // supply above lockout qualifies enable_i as the turn-on permit
    assign enabled = enable_i && !undervoltage_lockout_i;
    assign enable_rise = enabled && !enabled_prev_reg;
    assign latch_var = variant_latchoff_i;

    // captured select high means the lower trip level
    assign ov_trip = ov_sel_reg ? overvolt_trip_low_i : overvolt_trip_high_i;
    assign any_fault = ov_trip || tsd_hold_reg || thermal_shutdown_i || reverse_flow_block_i;

    // overvoltage debounce only while the switch conducts
    assign ovp_t.run = switch_reg && ov_trip;
    assign ovp_t.limit = OVP_DEB_CYC;

    // turn-on delay and retry intervals share one timer
    always_comb begin
        seq_t.run = 1'b0;
        seq_t.limit = TON_DELAY_CYC;
        case (state_reg)
            psfs_pkg::ST_DELAY: begin
                seq_t.run = 1'b1;
            end
            psfs_pkg::ST_SCP_WAIT: begin
                seq_t.run = 1'b1;
                seq_t.limit = latch_var ? LO_RETRY_CYC : AR_RETRY_CYC;
            end
            default: begin
                seq_t.run = 1'b0;
            end
        endcase
    end

    // clamped inrush timer, cleared whenever the limit releases
    assign scp_t.run = (state_reg == psfs_pkg::ST_SOFTSTART) && current_limit_active_i;
    assign scp_t.limit = SCP_CYC;

    // level select and thermal hysteresis
    always_comb begin
        enabled_prev_next = enabled;
        ov_sel_next = ov_sel_reg;
        if (enable_rise) begin
            ov_sel_next = overvolt_level_select_i;
        end
        tsd_hold_next = tsd_hold_reg;
        if (thermal_shutdown_i) begin
            tsd_hold_next = 1'b1;
        end else if (thermal_cool_i) begin
            tsd_hold_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enabled_prev_reg <= 1'b0;
            ov_sel_reg <= 1'b0;
            tsd_hold_reg <= 1'b0;
        end else begin
            enabled_prev_reg <= enabled_prev_next;
            ov_sel_reg <= ov_sel_next;
            tsd_hold_reg <= tsd_hold_next;
        end
    end

    // main sequence
    always_comb begin
        state_next = state_reg;
        retry_next = retry_reg;
        if (!enabled) begin
            state_next = psfs_pkg::ST_OFF;
            retry_next = '0;
        end else begin
            case (state_reg)
                psfs_pkg::ST_OFF: begin
                    state_next = psfs_pkg::ST_CHECK;
                end
                psfs_pkg::ST_CHECK: begin
                    if (!any_fault) begin
                        state_next = psfs_pkg::ST_DELAY;
                    end
                end
                psfs_pkg::ST_DELAY: begin
                    if (any_fault) begin
                        state_next = psfs_pkg::ST_CHECK;
                    end else if (seq_t.expired) begin
                        state_next = psfs_pkg::ST_SOFTSTART;
                    end
                end
                psfs_pkg::ST_SOFTSTART, psfs_pkg::ST_ON: begin
                    if (thermal_shutdown_i) begin
                        state_next = latch_var ? psfs_pkg::ST_LATCHED
                                               : psfs_pkg::ST_FAULT_WAIT;
                    end else if (ovp_t.expired) begin
                        state_next = latch_var ? psfs_pkg::ST_LATCHED
                                               : psfs_pkg::ST_FAULT_WAIT;
                    end else if (reverse_flow_block_i) begin
                        state_next = psfs_pkg::ST_REV_OFF;
                    end else if (state_reg == psfs_pkg::ST_SOFTSTART) begin
                        if (scp_t.expired) begin
                            if (latch_var && retry_reg == LO_RETRY_COUNT) begin
                                state_next = psfs_pkg::ST_LATCHED;
                            end else begin
                                state_next = psfs_pkg::ST_SCP_WAIT;
                            end
                        end else if (softstart_done_i) begin
                            state_next = psfs_pkg::ST_ON;
                            retry_next = '0;
                        end
                    end
                end
                psfs_pkg::ST_REV_OFF: begin
                    if (thermal_shutdown_i) begin
                        state_next = latch_var ? psfs_pkg::ST_LATCHED
                                               : psfs_pkg::ST_FAULT_WAIT;
                    end else if (ov_trip) begin
                        state_next = latch_var ? psfs_pkg::ST_LATCHED
                                               : psfs_pkg::ST_FAULT_WAIT;
                    end else if (!reverse_flow_block_i) begin
                        state_next = psfs_pkg::ST_ON;
                    end
                end
                psfs_pkg::ST_FAULT_WAIT: begin
                    if (!ov_trip && !tsd_hold_reg && !thermal_shutdown_i) begin
                        state_next = psfs_pkg::ST_CHECK;
                    end
                end
                psfs_pkg::ST_SCP_WAIT: begin
                    if (seq_t.expired) begin
                        state_next = psfs_pkg::ST_CHECK;
                        if (latch_var) begin
                            retry_next = retry_reg + RETRY_W'(1);
                        end
                    end
                end
                psfs_pkg::ST_LATCHED: begin
                    state_next = psfs_pkg::ST_LATCHED;
                end
                default: begin
                    state_next = psfs_pkg::ST_OFF;
                end
            endcase
        end
    end

    // output decode of the next state, registered
    always_comb begin
        switch_next = 1'b0;
        ss_next = 1'b0;
        ilim_next = 1'b0;
        latched_next = 1'b0;
        case (state_next)
            psfs_pkg::ST_SOFTSTART: begin
                switch_next = 1'b1;
                ss_next = 1'b1;
                ilim_next = 1'b1;
            end
            psfs_pkg::ST_ON: begin
                switch_next = 1'b1;
            end
            psfs_pkg::ST_LATCHED: begin
                latched_next = 1'b1;
            end
            default: begin
                switch_next = 1'b0;
            end
        endcase
        // reverse blocking alone never pulls the flag
        fault_next = 1'b0;
        if (enabled && ov_trip) begin
            fault_next = 1'b1;
        end
        if (tsd_hold_next) begin
            fault_next = 1'b1;
        end
        if (state_next == psfs_pkg::ST_SCP_WAIT || state_next == psfs_pkg::ST_LATCHED) begin
            fault_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= psfs_pkg::ST_OFF;
            retry_reg <= '0;
            switch_reg <= 1'b0;
            ss_reg <= 1'b0;
            ilim_reg <= 1'b0;
            fault_reg <= 1'b0;
            latched_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            retry_reg <= retry_next;
            switch_reg <= switch_next;
            ss_reg <= ss_next;
            ilim_reg <= ilim_next;
            fault_reg <= fault_next;
            latched_reg <= latched_next;
        end
    end

    assign switch_on_o = switch_reg;
    assign softstart_run_o = ss_reg;
    assign current_limit_en_o = ilim_reg;
    assign fault_flag_n_o = 1'b0;
    assign fault_flag_n_oe_o = fault_reg;
    assign overvolt_level_low_o = ov_sel_reg;
    assign latched_off_o = latched_reg;
    assign state_o = state_reg;
endmodule

/* File: psfs_map.svh */
// timing constants and counts for the protection switch fault sequencer
`ifndef PSFS_MAP_SVH
`define PSFS_MAP_SVH

`define PSFS_CLK_MHZ 250
`define PSFS_CNT_W 24

`define PSFS_OVP_DEB_US 512
`define PSFS_OVP_DEB_CYC (`PSFS_OVP_DEB_US * `PSFS_CLK_MHZ)

`define PSFS_TON_DELAY_MS 9
`define PSFS_TON_DELAY_CYC (`PSFS_TON_DELAY_MS * 1000 * `PSFS_CLK_MHZ)

`define PSFS_SCP_US 500
`define PSFS_SCP_CYC (`PSFS_SCP_US * `PSFS_CLK_MHZ)

`define PSFS_AR_RETRY_MS 64
`define PSFS_AR_RETRY_CYC (`PSFS_AR_RETRY_MS * 1000 * `PSFS_CLK_MHZ)

`define PSFS_LO_RETRY_MS 2
`define PSFS_LO_RETRY_CYC (`PSFS_LO_RETRY_MS * 1000 * `PSFS_CLK_MHZ)

`define PSFS_LO_RETRY_COUNT 4
`define PSFS_RETRY_W 3

`endif

/* File: psfs_pkg.sv */
// types of the protection switch fault sequencer
package psfs_pkg;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_CHECK,
        ST_DELAY,
        ST_SOFTSTART,
        ST_ON,
        ST_REV_OFF,
        ST_FAULT_WAIT,
        ST_SCP_WAIT,
        ST_LATCHED
    } psfs_state_e;

endpackage

/* File: psfs_tmr_if.sv */
// carrier between the sequencer and one of its interval timers
`timescale 1ns/100ps
interface psfs_tmr_if #(
    parameter int CNT_W = 24
);
    logic run;
    logic [CNT_W-1:0] limit;
    logic expired;

    modport ctl (output run, output limit, input expired);
    modport tmr (input run, input limit, output expired);
endinterface

/* File: psfs_timer.sv */
// interval timer: counts up to limit while run is high, clears when run drops
`timescale 1ns/100ps
module psfs_timer #(
    parameter int CNT_W = 24
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    psfs_tmr_if.tmr t
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (!t.run) begin
            count_next = '0;
        end else if (count_reg != t.limit) begin
            count_next = count_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // high from the (limit+1)-th cycle of run until run drops
    assign t.expired = t.run && (count_reg == t.limit);
endmodule

/* File: psfs_load_model.sv */
// load model: soft-start completion and inrush clamp on a short
`timescale 1ns/100ps
module psfs_load_model (
    // clock
    input wire logic clk_i,
    // ramp control and commanded short
    input wire logic ss_run_i,
    input wire logic short_i,
    // comparator answers
    output logic ss_done_o,
    output logic ilim_o
);
    logic [3:0] ramp_reg;
    // ramp only progresses while no short clamps it
    always_ff @(posedge clk_i) begin
        ramp_reg <= ss_run_i ? ramp_reg + {3'h0, !short_i} : 4'h0;
    end
    assign ilim_o = ss_run_i & short_i;
    assign ss_done_o = ss_run_i & (ramp_reg > 4'h6);
endmodule

/* File: psfs_sequencer_assertions.sv */
// assertion checker of the protection switch fault sequencer
`timescale 1ns/100ps
module psfs_seq_chk #(
    parameter int DEB = 20
) (
    // clock, reset and inputs
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic undervoltage_lockout_i,
    input wire logic overvolt_trip_high_i,
    input wire logic overvolt_trip_low_i,
    input wire logic reverse_flow_block_i,
    input wire logic thermal_shutdown_i,
    // outputs
    input wire logic switch_on_o,
    input wire logic softstart_run_o,
    input wire logic current_limit_en_o,
    input wire logic fault_flag_n_oe_o,
    input wire logic overvolt_level_low_o,
    input wire logic [3:0] state_o
);
    logic en;
    logic ov;
    logic [31:0] ovc_reg;
    logic [31:0] ovc_next;
    assign en = enable_i & !undervoltage_lockout_i;
    assign ov = overvolt_level_low_o ? overvolt_trip_low_i : overvolt_trip_high_i;
    // cycles the switch stays on under an overvoltage
    always_comb ovc_next = (en & ov & switch_on_o) ? ovc_reg + 32'h1 : 32'h0;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) ovc_reg <= 32'h0;
        else ovc_reg <= ovc_next;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_disabled_off: assert property (!en |=> state_o == 4'h0 && !switch_on_o)
        else $error("switch not off while disabled");
    a_ov_flag: assert property (en && ov && state_o != 4'h0 |=> fault_flag_n_oe_o)
        else $error("flag not low on overvoltage");
    a_select_frozen: assert property (state_o != 4'h0 && $past(state_o) != 4'h0
        |-> $stable(overvolt_level_low_o)) else $error("level select changed");
    a_ov_debounce: assert property (ovc_reg <= DEB + 3)
        else $error("switch on too long under overvoltage");
    a_ov_keeps_off: assert property (en && ov && !switch_on_o |=> !switch_on_o)
        else $error("switch on under overvoltage");
    a_reverse_off: assert property (reverse_flow_block_i && switch_on_o |=> !switch_on_o)
        else $error("switch on under reverse flow");
    a_thermal_off: assert property (thermal_shutdown_i && en
        |=> !switch_on_o && fault_flag_n_oe_o) else $error("thermal not handled");
    a_fully_on: assert property (state_o == 4'h4
        |-> switch_on_o && !current_limit_en_o && !softstart_run_o) else $error("on state wrong");
    c_on: cover property (state_o == 4'h4);
    c_short: cover property (state_o == 4'h7);
    c_latch: cover property (state_o == 4'h8);
endmodule
bind psfs_sequencer psfs_seq_chk #(.DEB(OVP_DEB_CYC)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
    .undervoltage_lockout_i(undervoltage_lockout_i), .overvolt_trip_high_i(overvolt_trip_high_i),
    .overvolt_trip_low_i(overvolt_trip_low_i), .reverse_flow_block_i(reverse_flow_block_i),
    .thermal_shutdown_i(thermal_shutdown_i), .switch_on_o(switch_on_o),
    .softstart_run_o(softstart_run_o), .current_limit_en_o(current_limit_en_o),
    .fault_flag_n_oe_o(fault_flag_n_oe_o), .overvolt_level_low_o(overvolt_level_low_o),
    .state_o(state_o));

/* File: psfs_sequencer_tb_top.sv */
// self-checking bench of the protection switch fault sequencer
`timescale 1ns/100ps
module psfs_sequencer_tb_top;
    localparam int DEB = 20;
    localparam int TON = 30;
    localparam int STARTUP_SHORT_PROTECT = 10;
    localparam int AR = 40;
    localparam int LO = 15;
    logic clk_i, rst_i, en, sel, var_l, uv, oth, otl, rev, thermal_shutdown, cool, shrt;
    logic ss_done, ilim, sw, ss_run, il_en, flag_n, flag_oe, ovl, latched;
    logic [3:0] st;
    // open-drain flag line with its pull-up
    wire flag_line_n = flag_oe ? flag_n : 1'b1;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    psfs_sequencer #(.OVP_DEB_CYC(24'(DEB)), .TON_DELAY_CYC(24'(TON)), .SCP_CYC(24'(STARTUP_SHORT_PROTECT)),
        .AR_RETRY_CYC(24'(AR)), .LO_RETRY_CYC(24'(LO))) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .overvolt_level_select_i(sel),
        .variant_latchoff_i(var_l), .undervoltage_lockout_i(uv), .overvolt_trip_high_i(oth),
        .overvolt_trip_low_i(otl), .reverse_flow_block_i(rev), .thermal_shutdown_i(thermal_shutdown),
        .thermal_cool_i(cool), .current_limit_active_i(ilim), .softstart_done_i(ss_done),
        .switch_on_o(sw), .softstart_run_o(ss_run), .current_limit_en_o(il_en),
        .fault_flag_n_o(flag_n), .fault_flag_n_oe_o(flag_oe), .overvolt_level_low_o(ovl),
        .latched_off_o(latched), .state_o(st));
    psfs_load_model load_u (.clk_i(clk_i), .ss_run_i(ss_run), .short_i(shrt),
        .ss_done_o(ss_done), .ilim_o(ilim));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wait_st(input logic [3:0] s, input int lim);
        n = 0;
        while (st !== s && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
    initial begin
        {rst_i, en, sel, var_l, uv, oth, otl, rev, thermal_shutdown, cool, shrt} = 11'h402;
        tick(20);
        rst_i = 1'b0;
        {en, sel} = 2'h3;
        tick(2);
        sel = 1'b0;
        wait_st(4'h3, 60);
        chk("ton", 1, n >= TON - 2 && n <= TON + 4);
        chk("sel_hold", 1, ovl);
        chk("ss_run", 1, ss_run);
        chk("ilim_ss", 1, il_en);
        wait_st(4'h4, 30);
        chk("ilim_on", 0, il_en);
        $display("test startup done");
        oth = 1'b1;
        tick(3);
        chk("ov_high_only", 1, flag_line_n);
        otl = 1'b1;
        tick(2);
        chk("ov_flag", 0, flag_line_n);
        wait_st(4'h6, 60);
        chk("ov_deb", 1, n >= DEB - 3 && n <= DEB + 2);
        chk("ov_hold", 0, sw);
        {oth, otl} = 2'h0;
        wait_st(4'h4, TON + 30);
        $display("test overvoltage done");
        rev = 1'b1;
        tick(2);
        chk("rev_sw", 0, sw);
        chk("rev_flag", 1, flag_line_n);
        rev = 1'b0;
        tick(2);
        chk("rev_back", 4, st);
        $display("test reverse done");
        {thermal_shutdown, cool} = 2'h2;
        tick(2);
        thermal_shutdown = 1'b0;
        tick(5);
        chk("tsd_hold", 0, sw);
        chk("tsd_flag", 0, flag_line_n);
        cool = 1'b1;
        wait_st(4'h3, TON + 20);
        chk("tsd_ss", 3, st);
        wait_st(4'h4, 30);
        $display("test thermal done");
        en = 1'b0;
        tick(2);
        chk("dis_off", 0, st);
        {en, shrt} = 2'h3;
        wait_st(4'h3, 60);
        tick(STARTUP_SHORT_PROTECT - 3);
        shrt = 1'b0;
        tick(1);
        shrt = 1'b1;
        tick(STARTUP_SHORT_PROTECT - 1);
        chk("scp_restart", 3, st);
        wait_st(4'h7, 10);
        chk("scp_flag", 0, flag_line_n);
        wait_st(4'h1, AR + 10);
        chk("ar_gap", 1, n >= AR - 2 && n <= AR + 3);
        wait_st(4'h7, 60);
        chk("ar_again", 7, st);
        {en, shrt} = 2'h0;
        $display("test short auto done");
        var_l = 1'b1;
        tick(2);
        {en, shrt} = 2'h3;
        for (int i = 0; i < 4; i++) begin
            wait_st(4'h7, 60);
            wait_st(4'h1, LO + 10);
            chk("lo_gap", 1, n >= LO - 2 && n <= LO + 3);
        end
        wait_st(4'h8, 60);
        tick(LO + 10);
        chk("lo_stay", 8, st);
        chk("lo_flag", 0, flag_line_n);
        chk("lo_latched", 1, latched);
        en = 1'b0;
        tick(2);
        {en, shrt} = 2'h2;
        wait_st(4'h4, TON + 30);
        chk("lo_clear", 4, st);
        $display("test short latch done");
        {thermal_shutdown, cool} = 2'h2;
        tick(2);
        {thermal_shutdown, cool} = 2'h1;
        tick(5);
        chk("tsd_latch", 8, st);
        uv = 1'b1;
        tick(2);
        chk("uv_off", 0, sw);
        chk("uv_st", 0, st);
        uv = 1'b0;
        wait_st(4'h4, TON + 30);
        chk("uv_clear", 4, st);
        $display("test thermal latch done");
        oth = 1'b1;
        tick(2);
        chk("ov_high_sel", 0, flag_line_n);
        chk("sel_low", 0, ovl);
        wait_st(4'h8, DEB + 10);
        chk("ov_latch", 8, st);
        tick(3);
        chk("ov_latch_sw", 0, sw);
        $display("test overvoltage latch done");
        summarize();
    end
endmodule
